/* File: verilog/power_fault_supervisor.sv */
// power fault supervisor: rails-valid output, fault flags, protection, aux outputs
`timescale 1ns/10ps
module power_fault_supervisor import pfs_pkg::*; #(
  parameter int unsigned SHORT_CYCLES_P = SHORT_CYCLES
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [7:0] AWADDR_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  output logic BVALID_O,
  input wire logic BREADY_I,
  output logic [1:0] BRESP_O,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  input wire logic [7:0] ARADDR_I,
  output logic RVALID_O,
  input wire logic RREADY_I,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  input wire logic SUPPLY_LOW_I,
  input wire logic SUPPLY_OVER_I,
  input wire logic OTP_DONE_I,
  input wire logic OVERHEAT_I,
  input wire logic HOT_LO_I,
  input wire logic HOT_HI_I,
  input wire logic [3:0] ILIM_I,
  input wire logic [3:0] BELOW_SC_I,
  input wire logic [3:0] RAIL_OK_I,
  input wire logic [3:0] RAMPING_I,
  input wire logic EN_PIN_I,
  output logic [3:0] RAIL_SWITCH_EN_O,
  output logic [3:0] RAIL_DISCHARGE_O,
  output logic [5:0] BUCK_PEAK_LIMIT_O,
  output logic RAILS_VALID_OUT_O,
  output logic IRQ_N_O,
  output logic [1:0] AUX_OUT_O,
  output logic [1:0] AUX_OE_O
);
  localparam int CW = $clog2(SHORT_CYCLES_P + 1);
  localparam logic [CW-1:0] SC_LAST = CW'(SHORT_CYCLES_P - 1);

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  mode_e mode_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, do_write;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_val, wmask, wbits;
  logic [3:0] wstrb_q, ctrl_q, en_q, dis_en_q, fault_q, on_q, on_d;
  logic [3:0] disch_q, fault_off_q, start_q, lim_set, sc_hit, short_set;
  logic [5:0] peak_q, aux_q;
  logic [15:0] flags_q, mask_q, flag_set, flag_clr;
  logic [7:0] lim_cnt_q [RAILS];
  logic [CW-1:0] sc_cnt_q [RAILS];
  logic swrst_q, pg_q, irq_n_q, wipe, operating, over_live, stop_live, hot_live;
  logic blocked, over_hold, pg_d;
  logic [1:0] aux_out_q, aux_oe_q, aux_lvl;

  assign wipe = mode_q == MD_SHUTDOWN;
  assign operating = mode_q == MD_STANDBY || mode_q == MD_ACTIVE;
  assign over_live = SUPPLY_OVER_I && operating;
  assign stop_live = OVERHEAT_I;
  assign hot_live = ctrl_q[CTRL_HOT_SEL_BIT] ? HOT_HI_I : HOT_LO_I;
  assign blocked = over_live || stop_live || flags_q[FL_OVER] || flags_q[FL_STOP];
  assign over_hold = over_live || flags_q[FL_OVER];
  assign do_write = !awready_q && !wready_q && !bvalid_q;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wbits = wdata_q & wmask;

  // bus write channels
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (AWVALID_I && awready_q) begin
        awaddr_q <= AWADDR_I;
        awready_q <= 1'b0;
      end
      if (WVALID_I && wready_q) begin
        wdata_q <= WDATA_I;
        wstrb_q <= WSTRB_I;
        wready_q <= 1'b0;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q < ADDR_END) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && BREADY_I) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // read data mux
  always_comb begin
    rd_val = 32'h00000000;
    if (is_reg(ARADDR_I, ADDR_CTRL)) begin
      rd_val[3:0] = ctrl_q;
    end else if (is_reg(ARADDR_I, ADDR_ENABLE)) begin
      rd_val[EN_LSB +: 4] = en_q;
      rd_val[DIS_LSB +: 4] = dis_en_q;
    end else if (is_reg(ARADDR_I, ADDR_LIMIT)) begin
      rd_val[PEAK0_LSB +: 3] = peak_q[2:0];
      rd_val[PEAK1_LSB +: 3] = peak_q[5:3];
    end else if (is_reg(ARADDR_I, ADDR_FLAGS)) begin
      rd_val[15:0] = flags_q;
      rd_val[FL_SUM_LSB +: 4] = flags_q[FL_SHORT_LSB +: 4];
    end else if (is_reg(ARADDR_I, ADDR_MASK)) begin
      rd_val[15:0] = mask_q;
    end else if (is_reg(ARADDR_I, ADDR_FAULT)) begin
      rd_val[3:0] = fault_q;
    end else if (is_reg(ARADDR_I, ADDR_STATUS)) begin
      rd_val[ST_LIMIT_LSB +: 4] = ILIM_I;
      rd_val[ST_HOT] = hot_live;
      rd_val[ST_OVER] = over_live;
      rd_val[ST_STOP] = stop_live;
      rd_val[ST_VALID] = pg_q;
      rd_val[ST_EN_LSB +: 4] = on_q;
      rd_val[ST_OK_LSB +: 4] = RAIL_OK_I;
      rd_val[ST_MODE_LSB +: 2] = mode_q;
    end else if (is_reg(ARADDR_I, ADDR_AUX)) begin
      rd_val[5:0] = aux_q;
    end
  end

  // bus read channels
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (ARVALID_I && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= (ARADDR_I < ADDR_END) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && RREADY_I) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // configuration registers return to defaults while shut down
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl_q <= CTRL_RESET;
      en_q <= 4'h0;
      dis_en_q <= 4'h0;
      peak_q <= 6'h00;
      mask_q <= MASK_RESET;
      aux_q <= 6'h00;
      swrst_q <= 1'b0;
    end else if (wipe) begin
      ctrl_q <= CTRL_RESET;
      en_q <= 4'h0;
      dis_en_q <= 4'h0;
      peak_q <= 6'h00;
      mask_q <= MASK_RESET;
      aux_q <= 6'h00;
      swrst_q <= 1'b0;
    end else begin
      swrst_q <= do_write && is_reg(awaddr_q, ADDR_CTRL) && wbits[CTRL_SWRST_BIT];
      if (do_write && is_reg(awaddr_q, ADDR_CTRL)) begin
        ctrl_q <= (ctrl_q & ~wmask[3:0]) | wbits[3:0];
      end
      if (do_write && is_reg(awaddr_q, ADDR_ENABLE)) begin
        dis_en_q <= (dis_en_q & ~wmask[DIS_LSB +: 4]) | wbits[DIS_LSB +: 4];
      end
      if (over_live || stop_live) begin
        en_q <= 4'h0;
      end else if (do_write && is_reg(awaddr_q, ADDR_ENABLE) && !blocked) begin
        en_q <= (en_q & ~wmask[EN_LSB +: 4]) | wbits[EN_LSB +: 4];
      end
      if (do_write && is_reg(awaddr_q, ADDR_LIMIT)) begin
        peak_q[2:0] <= (peak_q[2:0] & ~wmask[PEAK0_LSB +: 3]) | wbits[PEAK0_LSB +: 3];
        peak_q[5:3] <= (peak_q[5:3] & ~wmask[PEAK1_LSB +: 3]) | wbits[PEAK1_LSB +: 3];
      end
      if (do_write && is_reg(awaddr_q, ADDR_MASK)) begin
        mask_q <= (mask_q & ~wmask[15:0]) | wbits[15:0];
      end
      if (do_write && is_reg(awaddr_q, ADDR_AUX)) begin
        aux_q <= (aux_q & ~wmask[5:0]) | wbits[5:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mode_q <= MD_SHUTDOWN;
    end else if (SUPPLY_LOW_I || swrst_q) begin
      mode_q <= MD_SHUTDOWN;
    end else begin
      unique case (mode_q)
        MD_SHUTDOWN: mode_q <= MD_READ_CFG;
        MD_READ_CFG: mode_q <= OTP_DONE_I ? MD_STANDBY : MD_READ_CFG;
        MD_STANDBY: mode_q <= (|on_q) ? MD_ACTIVE : MD_STANDBY;
        MD_ACTIVE: mode_q <= (|on_q) ? MD_ACTIVE : MD_STANDBY;
      endcase
    end
  end

  assign on_d = en_q & ~flags_q[FL_SHORT_LSB +: 4] & ~short_set & {RAILS{!blocked && operating}};

  for (genvar i = 0; i < RAILS; i++) begin : g_rail
    // limit held for the full window
    assign lim_set[i] = ILIM_I[i] && lim_cnt_q[i] == LIMIT_MAX - 8'h01;
    // startup window or continuous overload reaches its end
    assign sc_hit[i] = on_q[i] && (start_q[i] || BELOW_SC_I[i]) && sc_cnt_q[i] == SC_LAST;
    assign short_set[i] = sc_hit[i] && BELOW_SC_I[i];
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        lim_cnt_q[i] <= 8'h00;
        sc_cnt_q[i] <= '0;
        start_q[i] <= 1'b1;
        fault_off_q[i] <= 1'b0;
      end else begin
        if (!ILIM_I[i]) begin
          lim_cnt_q[i] <= 8'h00;
        end else if (lim_cnt_q[i] != LIMIT_MAX) begin
          lim_cnt_q[i] <= lim_cnt_q[i] + 8'h01;
        end
        if (!on_q[i] || sc_hit[i] || !(start_q[i] || BELOW_SC_I[i])) begin
          sc_cnt_q[i] <= '0;
        end else begin
          sc_cnt_q[i] <= sc_cnt_q[i] + CW'(1);
        end
        if (!on_q[i]) begin
          start_q[i] <= 1'b1;
        end else if (sc_hit[i]) begin
          start_q[i] <= 1'b0;
        end
        if (wipe || on_q[i]) begin
          fault_off_q[i] <= on_q[i] && (short_set[i] || over_live || stop_live);
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      on_q <= 4'h0;
      disch_q <= 4'h0;
    end else begin
      on_q <= on_d;
      disch_q <= wipe ? 4'hF : (fault_off_q & dis_en_q & ~on_q);
    end
  end

  // flag set and write-one clear
  always_comb begin
    flag_set = 16'h0000;
    flag_set[FL_LIMIT_LSB +: 4] = lim_set;
    flag_set[FL_SHORT_LSB +: 4] = short_set;
    flag_set[FL_HOT] = hot_live;
    flag_set[FL_OVER] = over_live;
    flag_set[FL_STOP] = stop_live;
    flag_set[FL_RESET] = mode_q == MD_READ_CFG && OTP_DONE_I;
    flag_clr = (do_write && is_reg(awaddr_q, ADDR_FLAGS)) ? wbits[15:0] : 16'h0000;
    // clears ignored while the cause persists
    flag_clr[FL_OVER] = flag_clr[FL_OVER] && !over_live;
    flag_clr[FL_STOP] = flag_clr[FL_STOP] && !stop_live;
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      flags_q <= 16'h0000;
      fault_q <= 4'h0;
    end else if (wipe) begin
      flags_q <= 16'h0000;
      fault_q <= 4'h0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
      fault_q <= (fault_q & ~((do_write && is_reg(awaddr_q, ADDR_FAULT)) ? wbits[3:0] : 4'h0))
        | (on_q & ~start_q & ~RAMPING_I & ~RAIL_OK_I);
    end
  end

  assign pg_d = ctrl_q[CTRL_CONT_BIT] && operating && !(|(on_d & (~RAIL_OK_I | RAMPING_I)))
    && !blocked && !(ctrl_q[CTRL_HOLD_BIT] && |fault_q);

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pg_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      pg_q <= pg_d;
      irq_n_q <= !(|(flags_q & ~mask_q));
    end
  end

  for (genvar k = 0; k < 2; k++) begin : g_aux
    assign aux_lvl[k] = aux_q[AUX_LVL_LSB + k] && (!aux_q[AUX_SEQ_LSB + k] || EN_PIN_I)
      && !over_hold;
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        aux_out_q[k] <= 1'b0;
        aux_oe_q[k] <= 1'b0;
      end else begin
        aux_out_q[k] <= !aux_q[AUX_OD_LSB + k] && aux_lvl[k];
        // shared pin released when serving as clock input
        aux_oe_q[k] <= (aux_q[AUX_OD_LSB + k] ? !aux_lvl[k] : 1'b1)
          && (k == 0 || !ctrl_q[CTRL_PIN_SEL_BIT]);
      end
    end
  end

  assign AWREADY_O = awready_q;
  assign WREADY_O = wready_q;
  assign BVALID_O = bvalid_q;
  assign BRESP_O = bresp_q;
  assign ARREADY_O = arready_q;
  assign RVALID_O = rvalid_q;
  assign RDATA_O = rdata_q;
  assign RRESP_O = rresp_q;
  assign RAIL_SWITCH_EN_O = on_q;
  assign RAIL_DISCHARGE_O = disch_q;
  assign BUCK_PEAK_LIMIT_O = peak_q;
  assign RAILS_VALID_OUT_O = pg_q;
  assign IRQ_N_O = irq_n_q;
  assign AUX_OUT_O = aux_out_q;
  assign AUX_OE_O = aux_oe_q;

  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_short_hit;
    !wipe && on_q[1] && short_set[1];
  endsequence
  sequence s_rail_out;
    !on_q[1] && flags_q[FL_SHORT_LSB + 1];
  endsequence
  property p_short_off;
    s_short_hit |=> s_rail_out;
  endproperty
  a_short_off: assert property (p_short_off) else $error("short did not stop rail");
  property p_limit_cause;
    $rose(flags_q[FL_LIMIT_LSB]) |-> $past(ILIM_I[0]) && $past(lim_cnt_q[0]) == LIMIT_MAX - 8'h01;
  endproperty
  a_limit_cause: assert property (p_limit_cause) else $error("limit flag early");
  property p_irq;
    |(flags_q & ~mask_q) |=> !IRQ_N_O;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not asserted");
  property p_over_keep;
    over_live && flags_q[FL_OVER] |=> flags_q[FL_OVER];
  endproperty
  a_over_keep: assert property (p_over_keep) else $error("over flag cleared early");
  property p_stop_keep;
    !wipe && stop_live && flags_q[FL_STOP] |=> flags_q[FL_STOP] && on_q == 4'h0;
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("overheat handling wrong");
  property p_refuse;
    flags_q[FL_STOP] |=> on_q == 4'h0 ##1 on_q == 4'h0 || !flags_q[FL_STOP];
  endproperty
  a_refuse: assert property (p_refuse) else $error("rail on while overheat pending");
  property p_hold;
    ctrl_q[CTRL_HOLD_BIT] && |fault_q |=> !RAILS_VALID_OUT_O;
  endproperty
  a_hold: assert property (p_hold) else $error("valid with pending fault");
  property p_mode;
    !ctrl_q[CTRL_CONT_BIT] |=> !RAILS_VALID_OUT_O;
  endproperty
  a_mode: assert property (p_mode) else $error("valid outside continuous mode");
  property p_ramp;
    |(on_d & RAMPING_I) |=> !RAILS_VALID_OUT_O;
  endproperty
  a_ramp: assert property (p_ramp) else $error("valid while ramping");
  property p_aux_low;
    over_live |=> !AUX_OUT_O[0] && !AUX_OUT_O[1];
  endproperty
  a_aux_low: assert property (p_aux_low) else $error("aux high during supply over");
  property p_reset_flag;
    mode_q == MD_READ_CFG && OTP_DONE_I && !SUPPLY_LOW_I && !swrst_q |=> flags_q[FL_RESET];
  endproperty
  a_reset_flag: assert property (p_reset_flag) else $error("reset flag missing");
endmodule

/* File: verilog/pfs_pkg.sv */
// constants and types for the power fault supervisor
package pfs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned LIMIT_TIME_NS = 20000;
  localparam int unsigned LIMIT_CYCLES = (LIMIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] LIMIT_MAX = 8'(LIMIT_CYCLES);
  localparam int unsigned SHORT_TIME_NS = 1000000;
  localparam int unsigned SHORT_CYCLES = (SHORT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RAILS = 4;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_FAULT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_AUX = 8'h1C;
  localparam logic [7:0] ADDR_END = 8'h20;
  // control register fields
  localparam int CTRL_CONT_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam int CTRL_HOT_SEL_BIT = 2;
  localparam int CTRL_PIN_SEL_BIT = 3;
  localparam int CTRL_SWRST_BIT = 4;
  localparam logic [3:0] CTRL_RESET = 4'h1;
  // enable register fields
  localparam int EN_LSB = 0;
  localparam int DIS_LSB = 8;
  // peak limit fields, three bits each
  localparam int PEAK0_LSB = 0;
  localparam int PEAK1_LSB = 4;
  // flag and mask fields
  localparam int FL_LIMIT_LSB = 0;
  localparam int FL_SHORT_LSB = 4;
  localparam int FL_HOT = 12;
  localparam int FL_OVER = 13;
  localparam int FL_STOP = 14;
  localparam int FL_RESET = 15;
  localparam int FL_SUM_LSB = 16;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  // status fields
  localparam int ST_LIMIT_LSB = 0;
  localparam int ST_HOT = 4;
  localparam int ST_OVER = 5;
  localparam int ST_STOP = 6;
  localparam int ST_VALID = 7;
  localparam int ST_EN_LSB = 8;
  localparam int ST_OK_LSB = 12;
  localparam int ST_MODE_LSB = 16;
  // aux output fields
  localparam int AUX_OD_LSB = 0;
  localparam int AUX_LVL_LSB = 2;
  localparam int AUX_SEQ_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    MD_SHUTDOWN = 2'b00,
    MD_READ_CFG = 2'b01,
    MD_STANDBY = 2'b10,
    MD_ACTIVE = 2'b11
  } mode_e;
endpackage

/* File: sim/host_model.sv */
// host model: axi4-lite master with write and read tasks for any register address
`timescale 1ns/10ps
module host_model (
  input wire logic clk_i,
  output logic aw_v_o,
  input wire logic aw_r_i,
  output logic [7:0] aw_a_o,
  output logic w_v_o,
  input wire logic w_r_i,
  output logic [31:0] w_d_o,
  output logic [3:0] w_s_o,
  input wire logic b_v_i,
  output logic b_r_o,
  input wire logic [1:0] b_s_i,
  output logic ar_v_o,
  input wire logic ar_r_i,
  output logic [7:0] ar_a_o,
  input wire logic r_v_i,
  output logic r_r_o,
  input wire logic [31:0] r_d_i,
  input wire logic [1:0] r_s_i
);
  initial begin
    {aw_v_o, w_v_o, b_r_o, ar_v_o, r_r_o} = 5'h00;
    {aw_a_o, ar_a_o} = 16'h0000;
    w_d_o = 32'h0;
    w_s_o = 4'hF;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] s);
    @(posedge clk_i);
    aw_v_o <= 1'b1;
    aw_a_o <= a;
    w_v_o <= 1'b1;
    w_d_o <= d;
    b_r_o <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (aw_v_o && aw_r_i) begin
        aw_v_o <= 1'b0;
        aw_a_o <= ~a;
      end
      if (w_v_o && w_r_i) begin
        w_v_o <= 1'b0;
        w_d_o <= ~d;
      end
      if (b_v_i) begin
        s = b_s_i;
        b_r_o <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
    @(posedge clk_i);
    ar_v_o <= 1'b1;
    ar_a_o <= a;
    r_r_o <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (ar_v_o && ar_r_i) begin
        ar_v_o <= 1'b0;
        ar_a_o <= ~a;
      end
      if (r_v_i) begin
        d = r_d_i;
        s = r_s_i;
        r_r_o <= 1'b0;
        break;
      end
    end
  endtask
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the power fault supervisor
`timescale 1ns/10ps
module tb_top;
  import pfs_pkg::*;
  localparam int unsigned SC = 20;
  logic clk, rst_n, aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  logic [7:0] aw_a, ar_a;
  logic [31:0] w_d, r_d;
  logic [3:0] w_s, ilim, below, rail_ok, ramping, sw_en, dis;
  logic [1:0] b_s, r_s, aux_out, aux_oe, rsp;
  logic sup_low, sup_over, otp_done, overheat, hot_lo, hot_hi, en_pin, valid, irq_n;
  logic [5:0] peak;
  int n_fail = 0;
  int total_checks = 0;
  power_fault_supervisor #(.SHORT_CYCLES_P(SC)) u_dut (
    .CLK_SYS_I(clk), .RESET_N_I(rst_n), .AWVALID_I(aw_v), .AWREADY_O(aw_r), .AWADDR_I(aw_a),
    .WVALID_I(w_v), .WREADY_O(w_r), .WDATA_I(w_d), .WSTRB_I(w_s), .BVALID_O(b_v),
    .BREADY_I(b_r), .BRESP_O(b_s), .ARVALID_I(ar_v), .ARREADY_O(ar_r), .ARADDR_I(ar_a),
    .RVALID_O(r_v), .RREADY_I(r_r), .RDATA_O(r_d), .RRESP_O(r_s), .SUPPLY_LOW_I(sup_low),
    .SUPPLY_OVER_I(sup_over), .OTP_DONE_I(otp_done), .OVERHEAT_I(overheat),
    .HOT_LO_I(hot_lo), .HOT_HI_I(hot_hi), .ILIM_I(ilim), .BELOW_SC_I(below),
    .RAIL_OK_I(rail_ok), .RAMPING_I(ramping), .EN_PIN_I(en_pin), .RAIL_SWITCH_EN_O(sw_en),
    .RAIL_DISCHARGE_O(dis), .BUCK_PEAK_LIMIT_O(peak), .RAILS_VALID_OUT_O(valid),
    .IRQ_N_O(irq_n), .AUX_OUT_O(aux_out), .AUX_OE_O(aux_oe)
  );
  host_model u_host (
    .clk_i(clk), .aw_v_o(aw_v), .aw_r_i(aw_r), .aw_a_o(aw_a), .w_v_o(w_v), .w_r_i(w_r),
    .w_d_o(w_d), .w_s_o(w_s), .b_v_i(b_v), .b_r_o(b_r), .b_s_i(b_s), .ar_v_o(ar_v),
    .ar_r_i(ar_r), .ar_a_o(ar_a), .r_v_i(r_v), .r_r_o(r_r), .r_d_i(r_d), .r_s_i(r_s)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.wr(a, d, rsp);
  endtask
  task automatic rf(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    u_host.rd(a, d, rsp);
    chk(d & m, e);
  endtask
  task automatic t_boot;
    rf(ADDR_STATUS, 32'h30000, 32'h20000);
    rf(ADDR_CTRL, 32'h1F, 32'h01);
    rf(ADDR_FLAGS, 32'hFFFF, 32'h8000);
    chk(32'(irq_n), 32'h0);
    chk(32'(valid), 32'h1);
    wr(ADDR_FLAGS, 32'h8000);
    cyc(3);
    chk(32'(irq_n), 32'h1);
    wr(ADDR_END, 32'hFFFF_FFFF);
    chk(32'(rsp), 32'(RESP_SLVERR));
    rf(8'h24, 32'hFFFF_FFFF, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    $display("test boot done");
  endtask
  task automatic t_rails;
    wr(ADDR_LIMIT, 32'h55);
    cyc(2);
    chk(32'(peak), 32'h2D);
    rail_ok <= 4'hA;
    wr(ADDR_ENABLE, 32'h5);
    cyc(3);
    chk(32'(valid), 32'h0);
    rail_ok <= 4'hF;
    cyc(3);
    chk(32'(valid), 32'h1);
    ramping <= 4'h4;
    cyc(3);
    chk(32'(valid), 32'h0);
    ramping <= 4'h0;
    rail_ok <= 4'hE;
    cyc(SC + 10);
    wr(ADDR_CTRL, 32'h3);
    rail_ok <= 4'hF;
    cyc(3);
    chk(32'(valid), 32'h0);
    rf(ADDR_FAULT, 32'hF, 32'h1);
    wr(ADDR_FAULT, 32'h1);
    cyc(3);
    chk(32'(valid), 32'h1);
    wr(ADDR_CTRL, 32'h0);
    cyc(3);
    chk(32'(valid), 32'h0);
    wr(ADDR_CTRL, 32'h1);
    $display("test rails done");
  endtask
  task automatic t_limit;
    wr(ADDR_MASK, 32'h4);
    ilim <= 4'h5;
    cyc(205);
    rf(ADDR_FLAGS, 32'hF, 32'h5);
    rf(ADDR_STATUS, 32'hF, 32'h5);
    chk(32'(irq_n), 32'h0);
    ilim <= 4'h0;
    cyc(2);
    rf(ADDR_STATUS, 32'hF, 32'h0);
    wr(ADDR_FLAGS, 32'h1);
    cyc(3);
    chk(32'(irq_n), 32'h1);
    rf(ADDR_FLAGS, 32'hF, 32'h4);
    wr(ADDR_FLAGS, 32'h4);
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_CTRL, 32'h5);
    hot_lo <= 1'b1;
    cyc(5);
    rf(ADDR_STATUS, 32'h10, 32'h0);
    hot_hi <= 1'b1;
    cyc(2);
    rf(ADDR_STATUS, 32'h10, 32'h10);
    hot_hi <= 1'b0;
    wr(ADDR_CTRL, 32'h1);
    cyc(3);
    rf(ADDR_FLAGS, 32'h1000, 32'h1000);
    chk(32'(irq_n), 32'h0);
    hot_lo <= 1'b0;
    wr(ADDR_FLAGS, 32'h1000);
    cyc(3);
    chk(32'(irq_n), 32'h1);
    $display("test limit and warning done");
  endtask
  task automatic t_short;
    below <= 4'h2;
    wr(ADDR_ENABLE, 32'h207);
    cyc(SC + 10);
    chk(32'(sw_en), 32'h5);
    chk(32'(dis), 32'h2);
    rf(ADDR_FLAGS, 32'hF00F0, 32'h20020);
    rf(ADDR_STATUS, 32'hF00, 32'h500);
    chk(32'(irq_n), 32'h0);
    below <= 4'h0;
    wr(ADDR_FLAGS, 32'h20);
    cyc(3);
    chk(32'(sw_en), 32'h7);
    cyc(SC + 10);
    below <= 4'h2;
    cyc(SC - 5);
    chk(32'(sw_en), 32'h7);
    cyc(15);
    chk(32'(sw_en), 32'h5);
    below <= 4'h0;
    wr(ADDR_FLAGS, 32'h20);
    wr(ADDR_ENABLE, 32'h0);
    wr(ADDR_AUX, 32'hD);
    cyc(2);
    chk({28'h0, aux_out, aux_oe}, 32'hA);
    wr(ADDR_CTRL, 32'h9);
    cyc(2);
    chk(32'(aux_oe), 32'h0);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_AUX, 32'hC);
    cyc(2);
    chk({28'h0, aux_out, aux_oe}, 32'hF);
    wr(ADDR_AUX, 32'h3C);
    cyc(2);
    chk({28'h0, aux_out, aux_oe}, 32'h3);
    en_pin <= 1'b1;
    cyc(3);
    chk({28'h0, aux_out, aux_oe}, 32'hF);
    $display("test short and aux done");
  endtask
  task automatic t_prot(input int k);
    logic [31:0] fl;
    fl = 32'h2000 << k;
    wr(ADDR_ENABLE, 32'h3);
    sup_over <= (k == 0);
    overheat <= (k == 1);
    cyc(3);
    chk(32'(sw_en), 32'h0);
    chk(32'(dis), 32'h0);
    chk(k == 0 ? 32'(aux_out) : 32'h0, 32'h0);
    chk(32'(valid), 32'h0);
    chk(32'(irq_n), 32'h0);
    rf(ADDR_STATUS, 32'h30F60, 32'h20000 | (32'h20 << k));
    wr(ADDR_FLAGS, fl);
    rf(ADDR_FLAGS, fl, fl);
    {sup_over, overheat} <= 2'b00;
    cyc(3);
    chk(32'(valid), 32'h0);
    wr(ADDR_ENABLE, 32'h1);
    rf(ADDR_ENABLE, 32'hF, 32'h0);
    wr(ADDR_FLAGS, fl);
    cyc(3);
    chk(32'(valid), 32'h1);
    $display("test protection %0d done", k);
  endtask
  task automatic t_uvlo;
    wr(ADDR_ENABLE, 32'h301);
    sup_low <= 1'b1;
    otp_done <= 1'b0;
    cyc(3);
    chk({24'h0, sw_en, dis}, 32'h0F);
    sup_low <= 1'b0;
    cyc(5);
    rf(ADDR_STATUS, 32'h30080, 32'h10000);
    otp_done <= 1'b1;
    cyc(3);
    rf(ADDR_STATUS, 32'h30000, 32'h20000);
    chk(32'(valid), 32'h1);
    rf(ADDR_ENABLE, 32'hFFFF_FFFF, 32'h0);
    wr(ADDR_FLAGS, 32'h8000);
    wr(ADDR_CTRL, 32'h11);
    cyc(5);
    rf(ADDR_FLAGS, 32'h8000, 32'h8000);
    $display("test supply loss done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #2000000;
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    final_report;
  end
  initial begin
    rst_n = 1'b0;
    {sup_low, sup_over, overheat, hot_lo, hot_hi, en_pin} = 6'h00;
    otp_done = 1'b1;
    {ilim, below, ramping} = 12'h000;
    rail_ok = 4'hF;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    cyc(5);
    t_boot;
    t_rails;
    t_limit;
    t_short;
    t_prot(0);
    t_prot(1);
    t_uvlo;
    final_report;
  end
endmodule
